/* hdl/tmam_access_map.sv */
`timescale 1ns/1ps
// Overview of operation
// - Address bit 14 picks memory versus registers.
// - Memory-select field picks the target memory.
// - Bits 13..9 give stream number 0-31.
// - Top rate allows streams zero to fifteen only.
// - Bits 8..0 give channel number 0-511.
// - Channel range follows the stream rate.
// - Each received timeslot stored as one byte.
// - Local received memory holds 8192 byte slots.
// - Local received memory is read-only to host.
// - Reads return byte low, zeros high.
// - Local byte bit 7 is first bit received.
// - Backplane received memory holds 8192 byte slots.
// - Backplane received memory is read-only to host.
// - Backplane byte bit 7 is first bit received.
module tmam_access_map (
	// Clock and reset.
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// Host strobes and direction, asynchronous to mclk.
	input  wire logic                 host_cs_n,
	input  wire logic                 host_ds_n,
	input  wire logic                 host_rd_wr_n,
	// Host address and write data, asynchronous to mclk.
	input  wire logic [14:0]          host_addr,
	input  wire logic [15:0]          host_data_in,
	// Host read data and acknowledge, each straight from a flop.
	output logic [15:0]               host_data_out,
	output logic                      host_data_oe,
	output logic                      host_dtack_n,
	// Memory-select field from the control logic, same clock.
	input  wire logic [2:0]           memory_select_field,
	// Stream rate of each side, same clock.
	input  wire tmam_pkg::tmam_rate_t local_rate,
	input  wire tmam_pkg::tmam_rate_t backplane_rate,
	// Local receiver bit stream.
	input  wire logic                 local_rx_bit_vld,
	input  wire logic                 local_rx_bit,
	input  wire logic                 local_rx_first,
	input  wire logic [13:0]          local_rx_loc,
	// Backplane receiver bit stream.
	input  wire logic                 backplane_rx_bit_vld,
	input  wire logic                 backplane_rx_bit,
	input  wire logic                 backplane_rx_first,
	input  wire logic [13:0]          backplane_rx_loc,
	// Forwarded access to the register space and the switch map memories.
	output logic                      reg_req,
	output logic                      map_req,
	output logic                      map_backplane,
	output logic                      fwd_wr,
	output logic [13:0]               fwd_loc,
	output logic [15:0]               fwd_wdata,
	// Answers from the register space and the switch map memories.
	input  wire logic                 reg_ack,
	input  wire logic [15:0]          reg_rdata,
	input  wire logic                 map_ack,
	input  wire logic [15:0]          map_rdata
);

	// Sequencer states of one host cycle.
	typedef enum logic [2:0] {
		TMAM_IDLE,
		TMAM_DECODE,
		TMAM_RX_READ,
		TMAM_FORWARD,
		TMAM_ACK
	} tmam_state_t;

	// Pin sample: cs, ds, read flag, address, write data.
	typedef struct packed {
		logic        cs_n;
		logic        ds_n;
		logic        rd;
		logic [14:0] addr;
		logic [15:0] data;
	} tmam_pins_t;

	// Whole state of the block: two synchroniser stages, sequencer, latched cycle, outputs.
	typedef struct packed {
		tmam_pins_t  sync1;
		tmam_pins_t  sync2;
		tmam_state_t state;
		logic        space_mem;
		logic        rd;
		logic [2:0]  sel;
		logic [13:0] loc;
		logic [15:0] wdata;
		logic [15:0] data_out;
		logic        data_oe;
		logic        dtack_n;
		logic        reg_req;
		logic        map_req;
		logic        map_backplane;
		logic        fwd_wr;
	} tmam_ctl_t;

	// Registered state, its next value and the raw pin sample.
	tmam_ctl_t  ctl_ff;
	tmam_ctl_t  nxt_ctl;
	tmam_pins_t pins_now;

	// Read bytes of both stores and the synchronised strobe condition.
	logic [7:0] local_byte;
	logic [7:0] backplane_byte;
	logic       strobe_on;

	// Received-data memory of the local side.
	// It reads the latched location, so its byte stands one cycle after the latch.
	tmam_rx_store u_local_store (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.rx_bit_vld (local_rx_bit_vld),
		.rx_bit     (local_rx_bit),
		.rx_first   (local_rx_first),
		.rx_loc     (local_rx_loc),
		.rx_rate    (local_rate),
		.rd_loc     (ctl_ff.loc),
		.rd_byte    (local_byte)
	);

	// Received-data memory of the backplane side.
	tmam_rx_store u_backplane_store (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.rx_bit_vld (backplane_rx_bit_vld),
		.rx_bit     (backplane_rx_bit),
		.rx_first   (backplane_rx_first),
		.rx_loc     (backplane_rx_loc),
		.rx_rate    (backplane_rate),
		.rd_loc     (ctl_ff.loc),
		.rd_byte    (backplane_byte)
	);

	// All pins are gathered so one pair of flops covers them.
	// Address and data cross with the strobes; the host holds them steady before it
	// lowers a strobe, so a word is never taken while it changes.
	assign pins_now = '{
		cs_n: host_cs_n,
		ds_n: host_ds_n,
		rd:   host_rd_wr_n,
		addr: host_addr,
		data: host_data_in
	};

	// A cycle is seen only after both strobes have crossed the synchroniser.
	// Either strobe seen high again ends the cycle.
	assign strobe_on = !ctl_ff.sync2.cs_n && !ctl_ff.sync2.ds_n;

	// Access sequencer: latch, decode, fetch or forward, then hold the acknowledge
	// until the host lets go of its strobe.
	always_comb begin
		nxt_ctl = ctl_ff;
		nxt_ctl.sync1 = pins_now;
		nxt_ctl.sync2 = ctl_ff.sync1;
		nxt_ctl.reg_req = 1'b0;
		nxt_ctl.map_req = 1'b0;

		// Request pulses above last one cycle; other fields hold unless a state sets them.
		unique case (ctl_ff.state)
			// Latch the whole cycle at once so address, direction and select agree.
			TMAM_IDLE: begin
				if (strobe_on) begin
					nxt_ctl.space_mem = ctl_ff.sync2.addr[tmam_pkg::SPACE_BIT];
					nxt_ctl.loc = ctl_ff.sync2.addr[13:0];
					nxt_ctl.rd = ctl_ff.sync2.rd;
					nxt_ctl.wdata = ctl_ff.sync2.data;
					nxt_ctl.sel = memory_select_field;
					nxt_ctl.state = TMAM_DECODE;
				end
			end

			// Route the cycle: register space, a switch map or a received-data store.
			TMAM_DECODE: begin
				// Direction and a cleared read word are set for every route.
				nxt_ctl.fwd_wr = !ctl_ff.rd;
				nxt_ctl.data_out = tmam_pkg::DATA_RST;
				// Register space is reached whatever the select field holds.
				if (!ctl_ff.space_mem) begin
					nxt_ctl.reg_req = 1'b1;
					nxt_ctl.state = TMAM_FORWARD;
				end else begin
					unique case (ctl_ff.sel)
						// Switch maps live in the far logic; only the request is raised here.
						tmam_pkg::SEL_LOCAL_MAP: begin
							nxt_ctl.map_req = 1'b1;
							nxt_ctl.map_backplane = 1'b0;
							nxt_ctl.state = TMAM_FORWARD;
						end
						tmam_pkg::SEL_BP_MAP: begin
							nxt_ctl.map_req = 1'b1;
							nxt_ctl.map_backplane = 1'b1;
							nxt_ctl.state = TMAM_FORWARD;
						end
						// Received-data stores answer from here without the far logic.
						tmam_pkg::SEL_LOCAL_RX,
						tmam_pkg::SEL_BP_RX: begin
							if (ctl_ff.rd) begin
								// The array word for ctl_ff.loc is ready next cycle.
								nxt_ctl.state = TMAM_RX_READ;
							end else begin
								// Writes are dropped but still acknowledged.
								nxt_ctl.dtack_n = 1'b0;
								nxt_ctl.state = TMAM_ACK;
							end
						end
						default: begin
							// Unassigned select codes answer with zero so the host never hangs.
							nxt_ctl.dtack_n = 1'b0;
							nxt_ctl.data_oe = ctl_ff.rd;
							nxt_ctl.state = TMAM_ACK;
						end
					endcase
				end
			end

			// The store's byte for the latched location stands in this cycle.
			TMAM_RX_READ: begin
				// Out-of-range slots read as zero rather than alias another stream.
				if (ctl_ff.sel == tmam_pkg::SEL_LOCAL_RX) begin
					if (tmam_pkg::tmam_loc_ok(ctl_ff.loc, local_rate)) begin
						nxt_ctl.data_out = {tmam_pkg::RX_PAD_BYTE, local_byte};
					end
				end else begin
					if (tmam_pkg::tmam_loc_ok(ctl_ff.loc, backplane_rate)) begin
						nxt_ctl.data_out = {tmam_pkg::RX_PAD_BYTE, backplane_byte};
					end
				end
				// The enable rises with the acknowledge for in-range and refused slots alike.
				nxt_ctl.data_oe = 1'b1;
				nxt_ctl.dtack_n = 1'b0;
				nxt_ctl.state = TMAM_ACK;
			end

			// Wait for the side that was asked; an answer from the other side is ignored.
			TMAM_FORWARD: begin
				if (reg_ack && !ctl_ff.space_mem) begin
					nxt_ctl.data_out = reg_rdata;
					nxt_ctl.data_oe = ctl_ff.rd;
					nxt_ctl.dtack_n = 1'b0;
					nxt_ctl.state = TMAM_ACK;
				end else if (map_ack && ctl_ff.space_mem) begin
					nxt_ctl.data_out = map_rdata;
					nxt_ctl.data_oe = ctl_ff.rd;
					nxt_ctl.dtack_n = 1'b0;
					nxt_ctl.state = TMAM_ACK;
				end
			end

			// Hold the answer while the host still drives its strobes.
			TMAM_ACK: begin
				// Release only once the strobe is seen high, so a cycle is never taken twice.
				if (!strobe_on) begin
					nxt_ctl.dtack_n = 1'b1;
					nxt_ctl.data_oe = 1'b0;
					nxt_ctl.state = TMAM_IDLE;
				end
			end
		endcase
	end

	// Idle bus: strobes inactive, acknowledge released, data pins not driven.
	// Synchronisers reset to the idle strobe level, so no false cycle follows reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_ff <= '{
				sync1: '{cs_n: 1'b1, ds_n: 1'b1, rd: 1'b1, addr: 15'h0000, data: 16'h0000},
				sync2: '{cs_n: 1'b1, ds_n: 1'b1, rd: 1'b1, addr: 15'h0000, data: 16'h0000},
				state: TMAM_IDLE,
				space_mem: 1'b0,
				rd: 1'b1,
				sel: tmam_pkg::SEL_LOCAL_MAP,
				loc: tmam_pkg::LOC_RST,
				wdata: tmam_pkg::DATA_RST,
				data_out: tmam_pkg::DATA_RST,
				data_oe: 1'b0,
				dtack_n: 1'b1,
				reg_req: 1'b0,
				map_req: 1'b0,
				map_backplane: 1'b0,
				fwd_wr: 1'b0
			};
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// Outputs come straight from the state register.
	// Read data, enable and acknowledge change on one edge, so the host never sees
	// the acknowledge before the word. Forwarded fields stand until the next latch.
	assign host_data_out = ctl_ff.data_out;
	assign host_data_oe  = ctl_ff.data_oe;
	assign host_dtack_n  = ctl_ff.dtack_n;
	assign reg_req       = ctl_ff.reg_req;
	assign map_req       = ctl_ff.map_req;
	assign map_backplane = ctl_ff.map_backplane;
	assign fwd_wr        = ctl_ff.fwd_wr;
	assign fwd_loc       = ctl_ff.loc;
	assign fwd_wdata     = ctl_ff.wdata;

endmodule // tmam_access_map

/* hdl/tmam_pkg.sv */
package tmam_pkg;

	// Host address layout.
	localparam int unsigned ADDR_W     = 15;
	localparam int unsigned SPACE_BIT  = 14;
	localparam int unsigned STREAM_HI  = 13;
	localparam int unsigned STREAM_LO  = 9;
	localparam int unsigned CHAN_HI    = 8;
	localparam int unsigned CHAN_LO    = 0;
	localparam int unsigned STREAM_W   = 5;
	localparam int unsigned CHAN_W     = 9;
	localparam int unsigned LOC_W      = 14;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned BYTE_W     = 8;

	// Received-data memory geometry.
	localparam int unsigned RX_DEPTH   = 8192;
	localparam int unsigned RX_IDX_W   = 13;

	// Memory-select field codes.
	localparam logic [2:0] SEL_LOCAL_MAP = 3'h0;
	localparam logic [2:0] SEL_BP_MAP    = 3'h1;
	localparam logic [2:0] SEL_LOCAL_RX  = 3'h2;
	localparam logic [2:0] SEL_BP_RX     = 3'h3;

	// Upper byte of a received-data word and reset values.
	localparam logic [7:0]  RX_PAD_BYTE   = 8'h00;
	localparam logic [15:0] DATA_RST      = 16'h0000;
	localparam logic [13:0] LOC_RST       = 14'h0000;

	// Highest stream number at the top rate.
	localparam logic [4:0]  TOP_RATE_STREAM_MAX = 5'h0F;

	// Stream rate of one side.
	typedef enum logic [2:0] {
		TMAM_RATE_2M,
		TMAM_RATE_4M,
		TMAM_RATE_8M,
		TMAM_RATE_16M,
		TMAM_RATE_32M
	} tmam_rate_t;

	// Highest legal channel number for a rate.
	function automatic logic [8:0] tmam_chan_max(input tmam_rate_t rate);
		logic [8:0] m;
		m = 9'h01F;
		unique case (rate)
			TMAM_RATE_2M:  m = 9'h01F;
			TMAM_RATE_4M:  m = 9'h03F;
			TMAM_RATE_8M:  m = 9'h07F;
			TMAM_RATE_16M: m = 9'h0FF;
			TMAM_RATE_32M: m = 9'h1FF;
			default:       m = 9'h01F;
		endcase
		return m;
	endfunction

	// True when a stream and channel pair is usable at a rate.
	function automatic logic tmam_loc_ok(input logic [13:0] loc, input tmam_rate_t rate);
		logic ok;
		ok = (loc[CHAN_HI:CHAN_LO] <= tmam_chan_max(rate));
		if (rate == TMAM_RATE_32M && loc[STREAM_HI:STREAM_LO] > TOP_RATE_STREAM_MAX) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// Folds stream and channel into one of the 8192 byte slots.
	function automatic logic [12:0] tmam_rx_index(input logic [13:0] loc, input tmam_rate_t rate);
		logic [12:0] idx;
		if (rate == TMAM_RATE_32M) begin
			idx = {loc[12:9], loc[8:0]};
		end else begin
			idx = {loc[13:9], loc[7:0]};
		end
		return idx;
	endfunction

endpackage

/* hdl/tmam_rx_store.sv */
`timescale 1ns/1ps
module tmam_rx_store (
	// Clock and reset.
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// Serial input bits from the side's receiver.
	input  wire logic                 rx_bit_vld,
	input  wire logic                 rx_bit,
	input  wire logic                 rx_first,
	input  wire logic [13:0]          rx_loc,
	input  wire tmam_pkg::tmam_rate_t rx_rate,
	// Host read port, data one clock after the location.
	input  wire logic [13:0]          rd_loc,
	output logic [7:0]                rd_byte
);

	typedef struct packed {
		logic [2:0]  cnt;
		logic [6:0]  shift;
		logic [12:0] idx;
		logic [7:0]  rd_byte;
	} tmam_store_t;

	tmam_store_t st_ff;
	tmam_store_t nxt_st;
	logic [7:0]  mem [tmam_pkg::RX_DEPTH];
	logic        wr_en;
	logic [7:0]  wr_byte;

	// Bits are shifted in first-bit-first, so the first bit on the line ends in bit 7
	// whatever the line format calls it.
	always_comb begin
		nxt_st = st_ff;
		wr_en = 1'b0;
		wr_byte = {st_ff.shift, rx_bit};
		if (rx_bit_vld) begin
			if (rx_first) begin
				nxt_st.cnt = 3'h1;
				nxt_st.shift = {6'h00, rx_bit};
				nxt_st.idx = tmam_pkg::tmam_rx_index(rx_loc, rx_rate);
			end else begin
				nxt_st.cnt = st_ff.cnt + 3'h1;
				nxt_st.shift = {st_ff.shift[5:0], rx_bit};
				wr_en = (st_ff.cnt == 3'h7);
			end
		end
		nxt_st.rd_byte = mem[tmam_pkg::tmam_rx_index(rd_loc, rx_rate)];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Only the receiver writes the array; the host port has no path into it.
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[st_ff.idx] <= wr_byte;
		end
	end

	assign rd_byte = st_ff.rd_byte;

endmodule // tmam_rx_store

/* verif/tmam_access_map_assertions.sv */
`timescale 1ns/1ps
module tmam_access_map_chk (
	// Clock and reset.
	input wire logic                 mclk,
	input wire logic                 rst_n,
	// Host pins.
	input wire logic                 host_cs_n,
	input wire logic                 host_ds_n,
	input wire logic                 host_rd_wr_n,
	input wire logic [14:0]          host_addr,
	input wire logic [15:0]          host_data_out,
	input wire logic                 host_data_oe,
	input wire logic                 host_dtack_n,
	// Select, rates and forwarding.
	input wire logic [2:0]           memory_select_field,
	input wire tmam_pkg::tmam_rate_t local_rate,
	input wire tmam_pkg::tmam_rate_t backplane_rate,
	input wire logic                 reg_req,
	input wire logic                 map_req,
	input wire logic                 map_backplane,
	input wire logic [13:0]          fwd_loc,
	input wire logic                 reg_ack,
	input wire logic                 map_ack
);
	// The host holds its pins until the acknowledge drops, so pins stand for the latched cycle.
	tmam_pkg::tmam_rate_t rate_sel;
	logic                 rx_sel;
	logic                 rx_rd;
	assign rate_sel = memory_select_field[0] ? backplane_rate : local_rate;
	assign rx_sel = host_addr[14] && (memory_select_field inside {3'h2, 3'h3});
	assign rx_rd = rx_sel && host_data_oe;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	reg_space_a: assert property (reg_req |-> !host_addr[14])
		else $error("register request with memory bit set");
	map_pick_a: assert property (map_req |-> host_addr[14] && memory_select_field[2:1] == 2'h0
		&& map_backplane == memory_select_field[0]) else $error("wrong map chosen");
	loc_pass_a: assert property ((reg_req || map_req) |-> fwd_loc == host_addr[13:0])
		else $error("forwarded location differs");
	rx_pad_a: assert property (rx_rd |-> host_data_out[15:8] == 8'h00)
		else $error("upper byte not zero");
	top_stream_a: assert property (rx_rd && rate_sel == tmam_pkg::TMAM_RATE_32M
		&& host_addr[13] |-> host_data_out == 16'h0000) else $error("stream above 15 read data");
	low_chan_a: assert property (rx_rd && rate_sel == tmam_pkg::TMAM_RATE_2M
		&& host_addr[8:5] != 4'h0 |-> host_data_out == 16'h0000) else $error("channel above 31 read");
	rx_wr_ack_a: assert property ($fell(host_ds_n) && !host_cs_n && rx_sel && !host_rd_wr_n
		|-> ##[2:6] (!host_dtack_n && !host_data_oe)) else $error("discarded write not acked");
	no_drive_a: assert property (host_data_oe |-> host_rd_wr_n)
		else $error("data driven during write");
	fwd_ack_a: assert property ((reg_ack || map_ack) |=> !host_dtack_n)
		else $error("forwarded ack not passed on");
	release_a: assert property ($rose(host_ds_n) |-> ##[1:5] host_dtack_n)
		else $error("acknowledge not released");
	// Main traffic kinds.
	rx_read_c: cover property (rx_rd);
	map_c: cover property (map_req);
	reg_c: cover property (reg_req);
endmodule // tmam_access_map_chk
bind tmam_access_map tmam_access_map_chk tmam_access_map_chk_i (.mclk(mclk), .rst_n(rst_n),
	.host_cs_n(host_cs_n), .host_ds_n(host_ds_n), .host_rd_wr_n(host_rd_wr_n),
	.host_addr(host_addr), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
	.host_dtack_n(host_dtack_n), .memory_select_field(memory_select_field),
	.local_rate(local_rate), .backplane_rate(backplane_rate), .reg_req(reg_req),
	.map_req(map_req), .map_backplane(map_backplane), .fwd_loc(fwd_loc),
	.reg_ack(reg_ack), .map_ack(map_ack));

/* verif/tmam_access_map_bench.sv */
`timescale 1ns/1ps
module tmam_access_map_bench;
	logic mclk = 1'b0, rst_n = 1'b0, host_cs_n = 1'b1, host_ds_n = 1'b1, host_rd_wr_n = 1'b1;
	logic [14:0] host_addr = 15'h0000;
	logic [15:0] host_data_in = 16'h0000, host_data_out, fwd_wdata, reg_rdata, map_rdata;
	logic host_data_oe, host_dtack_n, reg_req, map_req, map_backplane, fwd_wr, reg_ack, map_ack;
	logic [2:0] memory_select_field = 3'h0;
	tmam_pkg::tmam_rate_t local_rate = tmam_pkg::TMAM_RATE_2M;
	tmam_pkg::tmam_rate_t backplane_rate = tmam_pkg::TMAM_RATE_2M;
	logic lvld = 1'b0, lbit = 1'b0, lfirst = 1'b0, bvld = 1'b0, bbit = 1'b0, bfirst = 1'b0;
	logic [13:0] lloc = 14'h0000, bloc = 14'h0000, fwd_loc;
	logic [31:0] seed = 32'hDCE44476;
	int bad_count = 0, check_count = 0;
	always #12.5 mclk = ~mclk;
	tmam_access_map tmam_access_map_i (.mclk(mclk), .rst_n(rst_n), .host_cs_n(host_cs_n),
		.host_ds_n(host_ds_n), .host_rd_wr_n(host_rd_wr_n), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.host_dtack_n(host_dtack_n), .memory_select_field(memory_select_field),
		.local_rate(local_rate), .backplane_rate(backplane_rate), .local_rx_bit_vld(lvld),
		.local_rx_bit(lbit), .local_rx_first(lfirst), .local_rx_loc(lloc),
		.backplane_rx_bit_vld(bvld), .backplane_rx_bit(bbit), .backplane_rx_first(bfirst),
		.backplane_rx_loc(bloc), .reg_req(reg_req), .map_req(map_req),
		.map_backplane(map_backplane), .fwd_wr(fwd_wr), .fwd_loc(fwd_loc),
		.fwd_wdata(fwd_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .map_ack(map_ack),
		.map_rdata(map_rdata));
	tmam_fwd_partner tmam_fwd_partner_i (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
		.map_req(map_req), .map_backplane(map_backplane), .fwd_loc(fwd_loc),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata), .map_ack(map_ack), .map_rdata(map_rdata));
	// Bench random source and highest channel for a rate code.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [8:0] cmax(input int r);
		return (9'h020 << r) - 9'h001;
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One host cycle; pins stay put until the acknowledge is seen, which bounds the wait.
	task automatic hacc(input logic rw, input logic [14:0] a, input logic [15:0] wd,
		output logic [15:0] rd);
		int n;
		@(posedge mclk); #2;
		host_rd_wr_n = rw; host_addr = a; host_data_in = wd; host_cs_n = 1'b0; host_ds_n = 1'b0;
		n = 0;
		do begin @(posedge mclk); #1; n++; end while (host_dtack_n !== 1'b0 && n < 40);
		rd = host_data_out;
		#1; host_ds_n = 1'b1; host_cs_n = 1'b1;
		while (host_dtack_n !== 1'b1 && n < 40) begin @(posedge mclk); #1; n++; end
		if (n >= 40) begin
			chk(16'hFFFF, 16'h0000);
			finish_test();
		end
		repeat (2) @(posedge mclk);
	endtask
	// Serial timeslot, first bit on the line carries byte bit 7.
	task automatic rxb(input int bp, input logic [13:0] l, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk); #2;
			if (bp != 0) begin bvld = 1'b1; bbit = b[7 - i]; bfirst = (i == 0); bloc = l; end
			else begin lvld = 1'b1; lbit = b[7 - i]; lfirst = (i == 0); lloc = l; end
		end
		@(posedge mclk); #2;
		lvld = 1'b0; bvld = 1'b0; lfirst = 1'b0; bfirst = 1'b0; lbit = ~lbit; bbit = ~bbit;
	endtask
	// Main sequence: received-data reads per side and rate, then forwarded accesses.
	initial begin
		logic [13:0] l;
		logic [15:0] rd;
		logic [7:0]  b;
		logic [8:0]  c;
		repeat (16) @(posedge mclk);
		#2 rst_n = 1'b1;
		for (int side = 0; side < 2; side++) begin
			for (int r = 0; r < 5; r++) begin
				@(posedge mclk); #2;
				if (side != 0) backplane_rate = tmam_pkg::tmam_rate_t'(r);
				else local_rate = tmam_pkg::tmam_rate_t'(r);
				memory_select_field = side != 0 ? tmam_pkg::SEL_BP_RX : tmam_pkg::SEL_LOCAL_RX;
				for (int k = 0; k < 3; k++) begin
					seed = lfsr_next(seed);
					c = k == 0 ? cmax(r) : seed[8:0] & cmax(r);
					l = {r == 4 ? {1'b0, seed[12:9]} : seed[13:9], c};
					b = seed[31:24];
					rxb(side, l, b);
					hacc(1'b1, {1'b1, l}, 16'h0000, rd);
					chk(rd, {8'h00, b});
					hacc(1'b0, {1'b1, l}, ~{8'h00, b}, rd);
					hacc(1'b1, {1'b1, l}, 16'h0000, rd);
					chk(rd, {8'h00, b});
				end
				l = r == 4 ? {5'h10, 9'h000} : {seed[13:9], cmax(r) + 9'h001};
				hacc(1'b1, {1'b1, l}, 16'h0000, rd);
				chk(rd, 16'h0000);
			end
		end
		$display("test received data done");
		for (int k = 0; k < 8; k++) begin
			if (k == 2 || k == 3) continue;
			@(posedge mclk); #2;
			memory_select_field = k[2:0];
			seed = lfsr_next(seed);
			l = seed[13:0];
			hacc(1'b1, {1'b0, l}, 16'h0000, rd);
			chk(rd, {2'b00, l});
			chk({15'h0000, fwd_wr}, 16'h0000);
			hacc(1'b1, {1'b1, l}, 16'h0000, rd);
			chk(rd, k < 2 ? {1'b1, k[0], l} : 16'h0000);
			hacc(1'b0, {1'b1, l}, seed[31:16], rd);
			if (k < 2) chk(fwd_wdata, seed[31:16]);
			if (k < 2) chk({15'h0000, fwd_wr}, 16'h0001);
		end
		$display("test forwarding done");
		finish_test();
	end
endmodule // tmam_access_map_bench

/* verif/tmam_fwd_partner.sv */
`timescale 1ns/1ps
module tmam_fwd_partner (
	// Clock and reset.
	input wire logic         mclk,
	input wire logic         rst_n,
	// Forwarded requests.
	input wire logic         reg_req,
	input wire logic         map_req,
	input wire logic         map_backplane,
	input wire logic [13:0]  fwd_loc,
	// Answers.
	output logic             reg_ack,
	output logic [15:0]      reg_rdata,
	output logic             map_ack,
	output logic [15:0]      map_rdata
);
	logic        busy;
	logic        is_map;
	logic        slow;
	int          cnt;
	logic [15:0] word;
	// Alternates prompt and slow answers; data is only valid with the ack, inverted otherwise.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			slow <= 1'b0;
			reg_ack <= 1'b0;
			map_ack <= 1'b0;
			word <= 16'h0000;
		end else begin
			reg_ack <= 1'b0;
			map_ack <= 1'b0;
			if (reg_req || map_req) begin
				busy <= 1'b1;
				is_map <= map_req;
				cnt <= slow ? 6 : 1;
				slow <= !slow;
				word <= {map_req, map_req & map_backplane, fwd_loc};
			end else if (busy && cnt > 0) begin
				cnt <= cnt - 1;
			end else if (busy) begin
				busy <= 1'b0;
				reg_ack <= !is_map;
				map_ack <= is_map;
			end
		end
	end
	assign reg_rdata = reg_ack ? word : ~word;
	assign map_rdata = map_ack ? word : ~word;
endmodule // tmam_fwd_partner
